// file: ebpsd_asserts.sv
// Checker on the port decode outputs
`timescale 1ns/1ps
module ebpsd_asserts
(
  input wire       MCLK,
  input wire       RST,
  input wire       LOW_POWER_HOLD,
  input wire [7:0] PIN_IN,
  input wire [7:0] PIN_OUT,
  input wire [7:0] PIN_OE,
  input wire [7:0] PIN_PULLUP,
  input wire [7:0] PIN_SLOW,
  input wire [7:0] PIN_READ,
  input wire [7:0] ANALOG_CH,
  input wire [7:0] FSEL_WORD,
  input wire [7:0] LATCH_WORD,
  input wire [7:0] DIR_WORD
);
  wire [7:0] f = FSEL_WORD, l = LATCH_WORD, d = DIR_WORD, oe = (f | d) & ~(f & l & d);
  reg  [1:0] n_r;
  reg        h_r, h2_r;
  // Edges since reset, so $past never looks into reset
  always @(posedge MCLK or posedge RST)
    if (RST) {n_r, h_r, h2_r} <= 4'h0;
    else {n_r, h_r, h2_r} <= {n_r + (n_r != 2'h3), LOW_POWER_HOLD, h_r};
  wire g = n_r == 2'h3 && !h_r;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  property p_oe; g |-> PIN_OE == $past(oe); endproperty
  a_oe: assert property (p_oe) else $error("bad oe");
  property p_out; g |-> PIN_OUT == $past(oe & l); endproperty
  a_out: assert property (p_out) else $error("bad out");
  property p_pu; g |-> PIN_PULLUP == $past(~f & l & ~d); endproperty
  a_pu: assert property (p_pu) else $error("bad pullup");
  property p_sl; g |-> PIN_SLOW == $past(f & ~d); endproperty
  a_sl: assert property (p_sl) else $error("bad slow");
  property p_rd; n_r == 2'h3 && !h2_r |-> PIN_READ == ($past(PIN_IN) ^ $past(f & l & d, 2)); endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_an; n_r != 2'h0 |-> ANALOG_CH == $past(PIN_IN); endproperty
  a_an: assert property (p_an) else $error("bad analog");
  property p_hd; n_r != 2'h0 && h_r |-> $stable({PIN_OE, PIN_OUT, PIN_PULLUP, PIN_SLOW}); endproperty
  a_hd: assert property (p_hd) else $error("hold moved");
  property p_rs; n_r == 2'h0 |-> {FSEL_WORD, LATCH_WORD, DIR_WORD, PIN_OE} == 32'h0; endproperty
  a_rs: assert property (p_rs) else $error("bad reset");
endmodule
bind p6pd_port ebpsd_asserts chk_u (.*);

// file: ebpsd_pins.sv
// Pin wires: device drive, outside driver, pull-up or float
`timescale 1ns/1ps
module ebpsd_pins
(
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] drv,
  input  wire [7:0] oe,
  input  wire [7:0] pu,
  input  wire [7:0] ext,
  input  wire [7:0] ext_en,
  output wire [7:0] lvl
);
  reg [7:0] last_r;
  // Pins with no drive, outside driver or pull-up flip each cycle, never a stale level
  assign lvl = oe & drv | ~oe & (ext_en & ext | ~ext_en & (pu | ~last_r));
  // Cleared in reset: an unknown history would keep floating pins unknown forever
  always @(posedge clk or posedge rst)
    if (rst) last_r <= 8'h00;
    else last_r <= lvl;
endmodule

// file: eight_bit_port_pin_state_decode_bench.sv
// Bench: port decoder against a bit-wise model
`timescale 1ns/1ps
`define CK(n,x,y) begin compares++; if ((x) !== (y)) begin fail_count++; $display("ERROR %s exp %h got %h", n, x, y); end end
module eight_bit_port_pin_state_decode_bench;
  reg         mclk = 0, rst = 1, wr = 0, hold = 0;
  reg  [23:0] w = 0, e = 0;
  reg  [15:0] s = 16'h1875;
  reg  [7:0]  ext = 0, een = 0, lvl_d = 0, f, l, d, x;
  wire [7:0]  po, oe, pu, sl, rd, an, fw, lw, dw, lvl;
  integer     fail_count = 0, compares = 0, cyc = 0, i;
  p6pd_port dut_u (.MCLK(mclk), .RST(rst), .FSEL_WR(wr), .FSEL_DATA(w[23:16]), .LATCH_WR(wr), .LATCH_DATA(w[15:8]),
    .DIR_WR(wr), .DIR_DATA(w[7:0]), .LOW_POWER_HOLD(hold), .PIN_IN(lvl), .PIN_OUT(po), .PIN_OE(oe),
    .PIN_PULLUP(pu), .PIN_SLOW(sl), .PIN_READ(rd), .ANALOG_CH(an), .FSEL_WORD(fw), .LATCH_WORD(lw), .DIR_WORD(dw));
  ebpsd_pins pins_u (.clk(mclk), .rst(rst), .drv(po), .oe(oe), .pu(pu), .ext(ext), .ext_en(een), .lvl(lvl));
  function [15:0] nx(input [15:0] a);
    nx = {a[14:0], a[15] ^ a[13] ^ a[12] ^ a[10]};
  endfunction
  task test_done;
  begin
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // All three words at once; the wait lets decode and read mask land
  task st(input [23:0] a);
  begin
    @(negedge mclk) {w, wr, ext, een} = {a, 1'b1, s};
    s = nx(s);
    @(negedge mclk) wr = 0;
    e = hold ? e : a;
    repeat (3) @(negedge mclk);
    {f, l, d} = e;
    x = (f | d) & ~(f & l & d);
    `CK("pins", {x, x & l, ~f & l & ~d, f & ~d, lvl_d ^ (f & l & d), lvl_d, w}, {oe, po, pu, sl, rd, an, fw, lw, dw})
  end
  endtask
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    lvl_d <= lvl;
    cyc <= cyc + 1;
    if (cyc == 1000) begin fail_count++; test_done; end
  end
  initial
  begin
    repeat (5) @(negedge mclk);
    `CK("reset", 72'h0, {oe, po, pu, sl, rd, an, fw, lw, dw})
    rst = 0;
    for (i = 0; i < 48; i++)
    begin
      st(i < 8 ? {{8{i[2]}}, {8{i[1]}}, {8{i[0]}}} : {s[7:0], nx(s)});
      if (i == 7) $display("test codes done");
    end
    $display("test random done");
    hold = 1;
    st(24'h00FFFF);
    hold = 0;
    st(w);
    $display("test hold done");
    test_done;
  end
endmodule

// file: p6pd_defs.vh
// Constants for the eight-bit port pin state decoder
`ifndef P6PD_DEFS_VH
`define P6PD_DEFS_VH

// ****************************************
// Port geometry
// ****************************************
`define P6PD_PORT_WIDTH 8

// ****************************************
// Reset values of the control words
// ****************************************
`define P6PD_FSEL_RESET 8'h00
`define P6PD_LATCH_RESET 8'h00
`define P6PD_DIR_RESET 8'h00

// ****************************************
// Control bit positions inside a pin code {fsel, latch, dir}
// ****************************************
`define P6PD_CODE_FSEL_BIT 2
`define P6PD_CODE_LATCH_BIT 1
`define P6PD_CODE_DIR_BIT 0

`endif

// file: p6pd_pin_decode.v
// Per-pin decode of one pin's three control bits into its drive state
`timescale 1ns/1ps
module p6pd_pin_decode
(
  input  wire fsel,
  input  wire latch,
  input  wire dir,
  output reg  drive_en,
  output reg  drive_val,
  output reg  pullup_en,
  output reg  slow_en,
  output reg  read_inv
);

  wire [2:0] code;

  assign code = {fsel, latch, dir};

  always @*
  begin
    drive_en  = 1'b0;
    drive_val = 1'b0;
    pullup_en = 1'b0;
    slow_en   = 1'b0;
    read_inv  = 1'b0;
    case (code)
      3'h0 :
      begin
        drive_en = 1'b0;
      end
      3'h2 :
      begin
        pullup_en = 1'b1;
      end
      3'h1, 3'h3 :
      begin
        drive_en  = 1'b1;
        drive_val = latch;
      end
      3'h4, 3'h6 :
      begin
        drive_en  = 1'b1;
        drive_val = latch;
        slow_en   = 1'b1;
      end
      3'h5 :
      begin
        drive_en  = 1'b1;
        drive_val = 1'b0;
      end
      3'h7 :
      begin
        read_inv = 1'b1;
      end
      default :
      begin
        drive_en = 1'b0;
      end
    endcase
  end

endmodule

// file: p6pd_port.v
// Eight-bit port: control words, per-pin decode, pin read-back and analog feed
//
// Operation
// - Pin n takes its state only from bit n of the three control words.
// - Pin n level always goes to analog channel n, whatever the control bits.
// - All three bits zero: output open, pin level still readable.
// - Select 0, latch 1, direction 0: not driven, internal pull-up on.
// - Select 0, direction 1: drive low for latch 0, high for latch 1.
// - Select 1, direction 0: drive latch value in slow-change mode.
// - Select 1, latch 0, direction 1: drive low at normal speed.
// - All bits one: output open, read inverted; otherwise read true level.
// - Input read location always returns pin levels, inverting configured pins.
// - All three control words reset to zero, so every pin starts open.
// - In halt or hold mode the pins keep the state held on entry.
`timescale 1ns/1ps
`include "p6pd_defs.vh"
module p6pd_port
#(
  parameter WIDTH = `P6PD_PORT_WIDTH
)
(
  input  wire             MCLK,
  input  wire             RST,
  input  wire             FSEL_WR,
  input  wire [WIDTH-1:0] FSEL_DATA,
  input  wire             LATCH_WR,
  input  wire [WIDTH-1:0] LATCH_DATA,
  input  wire             DIR_WR,
  input  wire [WIDTH-1:0] DIR_DATA,
  input  wire             LOW_POWER_HOLD,
  input  wire [WIDTH-1:0] PIN_IN,
  output wire [WIDTH-1:0] PIN_OUT,
  output wire [WIDTH-1:0] PIN_OE,
  output wire [WIDTH-1:0] PIN_PULLUP,
  output wire [WIDTH-1:0] PIN_SLOW,
  output wire [WIDTH-1:0] PIN_READ,
  output wire [WIDTH-1:0] ANALOG_CH,
  output wire [WIDTH-1:0] FSEL_WORD,
  output wire [WIDTH-1:0] LATCH_WORD,
  output wire [WIDTH-1:0] DIR_WORD
);

  // ****************************************
  // Control words
  // ****************************************
  reg  [WIDTH-1:0] fsel_r;
  reg  [WIDTH-1:0] latch_r;
  reg  [WIDTH-1:0] dir_r;

  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      fsel_r  <= `P6PD_FSEL_RESET;
      latch_r <= `P6PD_LATCH_RESET;
      dir_r   <= `P6PD_DIR_RESET;
    end
    else
    begin
      if (FSEL_WR)
        fsel_r <= FSEL_DATA;
      if (LATCH_WR)
        latch_r <= LATCH_DATA;
      if (DIR_WR)
        dir_r <= DIR_DATA;
    end
  end

  // ****************************************
  // Per-pin decode
  // ****************************************
  wire [WIDTH-1:0] drive_en;
  wire [WIDTH-1:0] drive_val;
  wire [WIDTH-1:0] pullup_en;
  wire [WIDTH-1:0] slow_en;
  wire [WIDTH-1:0] read_inv;

  // Isolated per-bit decoders keep pins independent
  genvar n;
  generate
    for (n = 0; n < WIDTH; n = n + 1)
    begin : g_pin
      p6pd_pin_decode u_dec
      (
        .fsel      (fsel_r[n]),
        .latch     (latch_r[n]),
        .dir       (dir_r[n]),
        .drive_en  (drive_en[n]),
        .drive_val (drive_val[n]),
        .pullup_en (pullup_en[n]),
        .slow_en   (slow_en[n]),
        .read_inv  (read_inv[n])
      );
    end
  endgenerate

  // ****************************************
  // Pin drive state, frozen in low-power hold
  // ****************************************
  reg  [WIDTH-1:0] pin_out_r;
  reg  [WIDTH-1:0] pin_oe_r;
  reg  [WIDTH-1:0] pin_pullup_r;
  reg  [WIDTH-1:0] pin_slow_r;
  reg  [WIDTH-1:0] read_inv_r;

  // Reset matches the all-zero decode: every pin open
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      pin_out_r    <= {WIDTH{1'b0}};
      pin_oe_r     <= {WIDTH{1'b0}};
      pin_pullup_r <= {WIDTH{1'b0}};
      pin_slow_r   <= {WIDTH{1'b0}};
      read_inv_r   <= {WIDTH{1'b0}};
    end
    else if (!LOW_POWER_HOLD)
    begin
      pin_out_r    <= drive_val & drive_en;
      pin_oe_r     <= drive_en;
      pin_pullup_r <= pullup_en;
      pin_slow_r   <= slow_en;
      read_inv_r   <= read_inv;
    end
  end

  // ****************************************
  // Read-back and analog feed
  // ****************************************
  reg  [WIDTH-1:0] pin_read_r;
  reg  [WIDTH-1:0] analog_r;

  // Sampled whatever the direction; hold does not stop reads
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      pin_read_r <= {WIDTH{1'b0}};
      analog_r   <= {WIDTH{1'b0}};
    end
    else
    begin
      pin_read_r <= PIN_IN ^ read_inv_r;
      analog_r   <= PIN_IN;
    end
  end

  assign PIN_OUT    = pin_out_r;
  assign PIN_OE     = pin_oe_r;
  assign PIN_PULLUP = pin_pullup_r;
  assign PIN_SLOW   = pin_slow_r;
  assign PIN_READ   = pin_read_r;
  assign ANALOG_CH  = analog_r;
  assign FSEL_WORD  = fsel_r;
  assign LATCH_WORD = latch_r;
  assign DIR_WORD   = dir_r;

endmodule
